/* core/jcm_mux.sv */
// Autoselect multiplexer routing processor debug port to combined chain or header
`timescale 1ns/1ps
module jcm_mux
  import jcm_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Processor debug port
  output logic      cpu_tck,
  output logic      cpu_tms,
  output logic      cpu_tdi,
  input  wire logic cpu_tdo,
  input  wire logic cpu_tdo_en,
  // Combined chain primitive
  input  wire logic combined_chain_cpu_primitive_tck,
  input  wire logic combined_chain_cpu_primitive_tms,
  input  wire logic combined_chain_cpu_primitive_tdi,
  output logic      combined_chain_cpu_primitive_tdo,
  output logic      combined_chain_cpu_primitive_tdo_en,
  // Processor-only header pins
  input  wire logic hdr_tck,
  input  wire logic hdr_tms,
  input  wire logic hdr_tdi,
  output logic      hdr_tdo_o,
  output logic      hdr_tdo_oe_b,
  // Current routing, high when the header owns the processor port
  output logic      hdr_selected
);

  typedef struct packed
  {
    jcm_sel_t sel;
  } jcm_mux_state_t;

  jcm_mux_state_t state_r;
  jcm_mux_state_t state_nxt;
  logic           hdr_tck_sync;

  // Pins are asynchronous to clk, so the sense goes through two flops
  jcm_sync #(
    .RESET_LEVEL (JCM_SYNC_RESET[0])
  ) u_tck_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (hdr_tck),
    .sync_out (hdr_tck_sync)
  );

  always_comb
  begin
    state_nxt = state_r;
    // Latch is sticky; only reset returns to the combined chain
    if (!hdr_tck_sync)
      state_nxt.sel = JCM_SEL_HEADER;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= '{sel: JCM_SEL_RESET};
    else
      state_r <= state_nxt;
  end

  assign hdr_selected = (state_r.sel == JCM_SEL_HEADER);

  // Data path is combinational: the debug clock is far too fast to retime at 25 MHz.
  // Pin drivers only change owner on selection change, which a loader must not straddle.
  always_comb
  begin
    unique case (state_r.sel)
      JCM_SEL_HEADER:
      begin
        cpu_tck = hdr_tck;
        cpu_tms = hdr_tms;
        cpu_tdi = hdr_tdi;
        hdr_tdo_o    = cpu_tdo;
        hdr_tdo_oe_b = ~cpu_tdo_en;
        combined_chain_cpu_primitive_tdo    = 1'b0;
        combined_chain_cpu_primitive_tdo_en = 1'b0;
      end
      JCM_SEL_COMBINED:
      begin
        cpu_tck = combined_chain_cpu_primitive_tck;
        cpu_tms = combined_chain_cpu_primitive_tms;
        cpu_tdi = combined_chain_cpu_primitive_tdi;
        hdr_tdo_o    = 1'b0;
        hdr_tdo_oe_b = 1'b1;
        combined_chain_cpu_primitive_tdo    = cpu_tdo;
        combined_chain_cpu_primitive_tdo_en = cpu_tdo_en;
      end
    endcase
  end

  // Selection stays combined while the synchronised clock stays high
  chk_default_holds: assert property (@(posedge clk) disable iff (!rst_b)
    (!hdr_selected && hdr_tck_sync) |=> !hdr_selected)
    else $error("selection left combined chain without a low header clock");

  chk_low_latches: assert property (@(posedge clk) disable iff (!rst_b)
    !hdr_tck_sync |=> hdr_selected)
    else $error("low header clock did not latch header selection");

  chk_latch_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    hdr_selected |=> hdr_selected [*8])
    else $error("header selection dropped without reset");

  chk_route_header: assert property (@(posedge clk) disable iff (!rst_b)
    hdr_selected |-> (cpu_tck == hdr_tck && cpu_tdi == hdr_tdi && hdr_tdo_o == cpu_tdo))
    else $error("header routing mismatch");

  chk_route_combined: assert property (@(posedge clk) disable iff (!rst_b)
    !hdr_selected |-> (cpu_tck == combined_chain_cpu_primitive_tck && hdr_tdo_oe_b))
    else $error("combined routing mismatch");

  chk_sync_delay: assert property (@(posedge clk) disable iff (!rst_b)
    (!hdr_selected && !hdr_tck ##1 !hdr_tck ##1 !hdr_tck) |=> hdr_selected)
    else $error("header clock low not seen within two flops");

  chk_no_filter: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(hdr_tck_sync) |=> hdr_selected)
    else $error("single low sample was filtered");

  chk_sense_watch: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(hdr_selected) |-> $past(!hdr_tck_sync))
    else $error("selection rose without a low header clock");

endmodule

/* core/jcm_pkg.sv */
// Package of constants for the processor debug chain autoselect multiplexer
package jcm_pkg;

  // Selection codes for the processor debug port routing
  typedef enum logic [0:0]
  {
    JCM_SEL_COMBINED = 1'b0,
    JCM_SEL_HEADER   = 1'b1
  } jcm_sel_t;

  // Reset value of the routing selection
  localparam jcm_sel_t JCM_SEL_RESET = JCM_SEL_COMBINED;

  // Synchroniser depth and its reset level (header clock idles high)
  localparam int         JCM_SYNC_STAGES = 2;
  localparam logic [1:0] JCM_SYNC_RESET  = 2'h3;

endpackage

/* core/jcm_sync.sv */
// Two-flop level synchroniser with a constant reset level
`timescale 1ns/1ps
module jcm_sync
  import jcm_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Asynchronous level in, synchronised level out
  input  wire logic async_in,
  output logic      sync_out
);

  typedef struct packed
  {
    logic [JCM_SYNC_STAGES-1:0] stage;
  } jcm_sync_state_t;

  jcm_sync_state_t state_r;
  jcm_sync_state_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    // First stage is read only by the second stage
    state_nxt.stage = {state_r.stage[0], async_in};
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= '{stage: {JCM_SYNC_STAGES{RESET_LEVEL}}};
    else
      state_r <= state_nxt;
  end

  assign sync_out = state_r.stage[JCM_SYNC_STAGES-1];

endmodule

/* verif/jcm_prog_model.sv */
// Behavioural programmer on the processor-only debug header
`timescale 1ns/1ps
module jcm_prog_model
(
  // Start from bench
  input  wire logic go,
  // Header pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // Clock stands high between frames, as the pull-up would hold it
  initial
  begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
    wait (go);
    repeat (4)
    begin
      tck = 1'b0;
      tdi = ~tdi;
      #160;
      tck = 1'b1;
      tms = ~tms;
      #160;
    end
  end
endmodule

/* verif/tb_jcm_mux.sv */
// Bench for the debug chain autoselect multiplexer
`timescale 1ns/1ps
module tb_jcm_mux;
  logic clk, rst_b, go, glitch, c_tck, c_tms, c_tdi, p_tck, p_tms, p_tdi, m_tck, m_tms, m_tdi;
  logic c_tdo, c_en, p_tdo, p_en, h_tck, h_tdo, h_oe_b, sel;
  int   n_fail, checks, cyc;
  // Bench glitch overrides the programmer's clock line
  assign h_tck = glitch ? 1'b0 : m_tck;
  jcm_mux jcm_mux_inst (.clk(clk), .rst_b(rst_b), .cpu_tck(c_tck), .cpu_tms(c_tms), .cpu_tdi(c_tdi),
    .cpu_tdo(c_tdo), .cpu_tdo_en(c_en), .combined_chain_cpu_primitive_tck(p_tck),
    .combined_chain_cpu_primitive_tms(p_tms), .combined_chain_cpu_primitive_tdi(p_tdi),
    .combined_chain_cpu_primitive_tdo(p_tdo), .combined_chain_cpu_primitive_tdo_en(p_en),
    .hdr_tck(h_tck), .hdr_tms(m_tms), .hdr_tdi(m_tdi), .hdr_tdo_o(h_tdo), .hdr_tdo_oe_b(h_oe_b),
    .hdr_selected(sel));
  jcm_prog_model jcm_prog_model_inst (.go(go), .tck(m_tck), .tms(m_tms), .tdi(m_tdi), .tdo(h_tdo));
  task chk(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %0t bit got %b expected %b", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task t_default;
    repeat (5) @(posedge clk);
    #1;
    chk(sel, 1'b0);
    chk(c_tms, p_tms);
    chk(p_tdo, c_tdo);
    chk(h_oe_b, 1'b1);
  endtask
  task t_glitch;
    @(posedge clk);
    #1 glitch = 1'b1;
    @(posedge clk);
    #1 glitch = 1'b0;
    @(posedge clk);
    #1 chk(sel, 1'b0);
    @(posedge clk);
    #1 chk(sel, 1'b1);
    repeat (9) @(posedge clk);
    #1 chk(sel, 1'b1);
    chk(c_tck, h_tck);
    chk(h_oe_b, ~c_en);
    chk(p_en, 1'b0);
  endtask
  task t_reset;
    rst_b = 1'b0;
    #1 chk(sel, 1'b0);
    @(posedge clk);
    #1 rst_b = 1'b1;
    go = 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(sel, 1'b1);
    chk(c_tdi, m_tdi);
    chk(h_tdo, c_tdo);
  endtask
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    p_tck <= cyc[0];
    p_tms <= cyc[1];
    if (cyc > 2000)
    begin
      n_fail++;
      close_out;
    end
  end
  initial
  begin
    {rst_b, go, glitch, c_tdo, c_en, p_tck, p_tms, p_tdi, n_fail, checks, cyc} = '0;
    c_tdo = 1'b1;
    c_en = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    t_default;
    t_glitch;
    t_reset;
    close_out;
  end
endmodule
